/* dv/ee_link_monitor.sv */
// Link checker: framing and output timing on the three wire link
`timescale 1ns/1ns
module ee_link_monitor #(
  parameter int ADDR_W8 = 7,
  parameter int MIN_SELECT_LOW_TIME     = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Link signals
  input wire logic chip_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic word_size_select,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  logic       sk_reg;
  logic [7:0] age_reg;
  logic [7:0] rises_reg;
  logic [7:0] low_reg;
  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  // Age of last shift clock rise, rises per frame, select low time
  wire       sk_rise    = shift_clock & ~sk_reg;
  wire [7:0] age_next   = sk_rise ? 8'h00 : age_reg + {7'h0, ~&age_reg};
  wire [7:0] rises_next = chip_select ? rises_reg + {7'h0, sk_rise} : 8'h00;
  wire [7:0] low_next   = chip_select ? 8'h00 : low_reg + {7'h0, ~&low_reg};
  wire [7:0] aw         = word_size_select ? 8'(ADDR_W8 - 1) : 8'(ADDR_W8);
  wire [7:0] dw         = word_size_select ? 8'h10 : 8'h08;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      {sk_reg, age_reg, rises_reg, low_reg} <= {1'b0, 8'hff, 16'h0000};
    else
      {sk_reg, age_reg, rises_reg, low_reg} <=
        {shift_clock, age_next, rises_next, low_next};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  chk_start_bit_one:
    assert property (chip_select && sk_rise && rises_reg == 8'h00
      |-> serial_in) else $error("frame did not open with a one");
  chk_data_on_low:
    assert property (chip_select && $past(chip_select) && $changed(serial_in)
      |-> !shift_clock) else $error("serial_in moved while clock high");
  chk_frame_length:
    assert property ($fell(chip_select) && rises_reg != 8'h00
      |-> rises_reg == aw + 8'h03 || rises_reg == aw + dw + 8'h03)
    else $error("frame clock count wrong");
  chk_org_steady:
    assert property (chip_select && $past(chip_select)
      |-> $stable(word_size_select)) else $error("org moved in frame");
  chk_select_low_min:
    assert property ($rose(chip_select) |-> low_reg >= MIN_SELECT_LOW_TIME - 1)
    else $error("select low time too short");
  chk_out_at_rise:
    assert property (serial_out_en && $past(serial_out_en)
      && $changed(serial_out) && age_reg < 8'h3c |-> age_reg <= 8'h08)
    else $error("read output moved away from clock rise");
  chk_dummy_zero:
    assert property ($rose(serial_out_en) |-> !serial_out)
    else $error("output drive began with a one");
  chk_out_release:
    assert property (!chip_select [*8] |-> !serial_out_en)
    else $error("output still driven after deselect");
endmodule

/* dv/tb_three_wire_eeprom_command_port.sv */
// Testbench: host and EEPROM ends joined over the three wire link
`timescale 1ns/1ns
module tb_three_wire_eeprom_command_port;
  logic                 sys_clk;
  logic                 rstn;
  logic                 cmd_valid;
  ee_pkg::host_cmd_type cmd;
  logic [6:0]           cmd_addr;
  logic [15:0]          cmd_data;
  logic                 word_mode;
  logic                 cmd_ready;
  logic                 done;
  logic                 rd_valid;
  logic [15:0]          rd_data;
  logic                 prog_busy;
  logic                 prog_enabled;
  int                   errors;
  int                   num_checks;
  logic                 busy_seen = 1'b0;

  ee_link_if link ();
  ee_host ee_host_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .word_mode(word_mode), .cmd_ready(cmd_ready),
    .done(done), .rd_valid(rd_valid), .rd_data(rd_data));
  ee_device #(.PROG_CYCLES(200)) ee_device_inst (.sys_clk(sys_clk),
    .rstn(rstn), .link(link), .prog_busy(prog_busy),
    .prog_enabled(prog_enabled));
  ee_link_monitor ee_link_monitor_inst (.sys_clk(sys_clk), .rstn(rstn),
    .chip_select(link.chip_select), .shift_clock(link.shift_clock),
    .serial_in(link.serial_in), .word_size_select(link.word_size_select),
    .serial_out(link.serial_out), .serial_out_en(link.serial_out_en));

  // Remembers any programming cycle seen
  always @(posedge sys_clk)
    if (prog_busy === 1'b1)
      busy_seen <= 1'b1;

  // Compare helpers
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0, got}, {15'h0, exp});
  endtask

  // One request; waits for done, returns rd_valid seen with it
  task automatic send(input ee_pkg::host_cmd_type c, input logic [6:0] a,
                      input logic [15:0] d, input logic wm, output logic rv);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 9000)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    cmd_addr  <= a;
    cmd_data  <= d;
    word_mode <= wm;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 9000)
    begin
      @(negedge sys_clk);
      n++;
    end
    rv = rd_valid;
    check_bit(done, 1'b1);
    check_bit(cmd_ready, 1'b1);
  endtask

  // Read one location; byte reads look at the low byte only
  task automatic read_chk(input logic [6:0] a, input logic wm,
                          input logic [15:0] exp);
    logic rv;
    send(ee_pkg::cmd_read, a, 16'h0000, wm, rv);
    check_bit(rv, 1'b1);
    check_word(wm ? rd_data : {8'h00, rd_data[7:0]}, exp);
  endtask

  task automatic test_power_up;
    logic rv;
    check_bit(prog_enabled, 1'b0);
    send(ee_pkg::cmd_write, 7'h05, 16'h00a5, 1'b0, rv);
    check_bit(busy_seen, 1'b0);
    read_chk(7'h05, 1'b0, 16'h00ff);
  endtask

  task automatic test_program;
    logic rv;
    send(ee_pkg::program_enable_cmd, 7'h00, 16'h0000, 1'b0, rv);
    check_bit(prog_enabled, 1'b1);
    send(ee_pkg::cmd_write, 7'h05, 16'h00a5, 1'b0, rv);
    check_bit(prog_busy, 1'b0);
    check_bit(busy_seen, 1'b1);
    read_chk(7'h05, 1'b0, 16'h00a5);
    send(ee_pkg::cmd_write, 7'h06, 16'h003c, 1'b0, rv);
    read_chk(7'h03, 1'b1, 16'hff3c);
    send(ee_pkg::cmd_erase, 7'h06, 16'h0000, 1'b0, rv);
    read_chk(7'h06, 1'b0, 16'h00ff);
    check_bit(prog_enabled, 1'b1);
  endtask

  task automatic test_all;
    logic rv;
    send(ee_pkg::write_all_cmd, 7'h00, 16'h1234, 1'b1, rv);
    read_chk(7'h3f, 1'b1, 16'h1234);
    read_chk(7'h7f, 1'b0, 16'h0012);
    send(ee_pkg::erase_all_cmd, 7'h00, 16'h0000, 1'b1, rv);
    read_chk(7'h15, 1'b1, 16'hffff);
  endtask

  task automatic test_disable;
    logic rv;
    send(ee_pkg::program_disable_cmd, 7'h00, 16'h0000, 1'b1, rv);
    check_bit(prog_enabled, 1'b0);
    send(ee_pkg::cmd_write, 7'h02, 16'habcd, 1'b1, rv);
    read_chk(7'h02, 1'b1, 16'hffff);
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Clock, watchdog and main sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #600000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {errors, num_checks} = '0;
    {rstn, cmd_valid, cmd_addr, cmd_data, word_mode} = '0;
    cmd = ee_pkg::cmd_read;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    test_power_up();
    test_program();
    test_all();
    test_disable();
    tally_and_finish();
  end
endmodule

/* verilog/ee_device.sv */
// EEPROM end: command decoder, self-timed programming, array
`timescale 1ns/1ns
module ee_device #(
  parameter int ADDR_W8     = ee_pkg::ADDR_W8_1K,
  parameter bit IGNORE_MSB  = 1'b0,
  parameter int PROG_CYCLES = ee_pkg::PROGRAM_CYCLE_CYCLES
) (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Link
  ee_link_if.device   link,
  // User-side status
  output logic        prog_busy,
  output logic        prog_enabled
);

  localparam int IDX_W = ADDR_W8 - 1 - (IGNORE_MSB ? 1 : 0);
  localparam int NW    = 2 ** IDX_W;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] cs_sync_reg;
  logic [2:0] sk_sync_reg;
  logic [1:0] di_sync_reg;
  logic [1:0] org_sync_reg;

  // Two flops, third only for edge detection
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_sync_reg  <= 3'h0;
      sk_sync_reg  <= 3'h0;
      di_sync_reg  <= 2'h0;
      org_sync_reg <= 2'h0;
    end
    else
    begin
      cs_sync_reg  <= {cs_sync_reg[1:0], link.chip_select};
      sk_sync_reg  <= {sk_sync_reg[1:0], link.shift_clock};
      di_sync_reg  <= {di_sync_reg[0], link.serial_in};
      org_sync_reg <= {org_sync_reg[0], link.word_size_select};
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ee_pkg::dev_state_type state_reg;
  logic [1:0]            op_reg;
  logic [ADDR_W8-1:0]    addr_reg;
  logic [15:0]           data_reg;
  logic [15:0]           rsh_reg;
  logic [4:0]            cnt_reg;
  logic                  en_reg;
  logic                  busy_reg;
  logic [31:0]           pcnt_reg;
  logic                  pend_all_reg;
  logic [IDX_W-1:0]      pend_idx_reg;
  logic [15:0]           pend_data_reg;
  logic [1:0]            pend_mask_reg;
  logic [5:0]            low_cnt_reg;
  logic                  armed_reg;
  logic                  show_reg;
  logic                  so_reg;
  logic                  so_en_reg;
  logic [15:0]           mem [NW];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire cs_s      = cs_sync_reg[1];
  wire cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire sk_rise   = cs_s & sk_sync_reg[1] & ~sk_sync_reg[2];
  wire di_s      = di_sync_reg[1];
  wire word_mode = org_sync_reg[1];

  // Field lengths from organisation
  wire [4:0] aw_last = word_mode ? 5'(ADDR_W8 - 2) : 5'(ADDR_W8 - 1);
  wire [4:0] dw_last = word_mode ? 5'(ee_pkg::DATA_W_WORD - 1)
                                 : 5'(ee_pkg::DATA_W_BYTE - 1);

  // Address as seen in the current cycle
  wire [ADDR_W8-1:0] addr_full = {addr_reg[ADDR_W8-2:0], di_s};
  wire [ADDR_W8-1:0] addr_src  = (state_reg == ee_pkg::D_ADDR) ? addr_full
                                                               : addr_reg;
  wire [1:0] ext = word_mode ? addr_src[ADDR_W8-2 -: 2]
                             : addr_src[ADDR_W8-1 -: 2];
  // Top address bit drops out when the index is narrower
  wire [IDX_W-1:0] idx  = word_mode ? addr_src[IDX_W-1:0]
                                    : addr_src[IDX_W:1];
  wire             lane = addr_src[0];

  wire [15:0] data_full = {data_reg[14:0], di_s};
  wire [15:0] wdata     = word_mode ? data_full
                                    : {data_full[7:0], data_full[7:0]};
  wire [15:0] rd_word   = mem[idx];
  wire [15:0] rd_load   = word_mode ? rd_word
                        : {(lane ? rd_word[15:8] : rd_word[7:0]), 8'h00};

  wire is_ext    = (op_reg == ee_pkg::OP_EXT);
  wire last_addr = sk_rise && state_reg == ee_pkg::D_ADDR
                   && cnt_reg == aw_last;
  wire last_data = sk_rise && state_reg == ee_pkg::D_DATA
                   && cnt_reg == dw_last;
  wire go_read   = last_addr && op_reg == ee_pkg::OP_READ;
  wire go_erase  = last_addr && op_reg == ee_pkg::OP_ERASE;
  wire go_erall  = last_addr && is_ext && ext == ee_pkg::EXT_ERALL;
  wire go_write  = last_data && op_reg == ee_pkg::OP_WRITE;
  wire go_wrall  = last_data && is_ext && ext == ee_pkg::EXT_WRALL;
  wire go_en     = last_addr && is_ext && ext == ee_pkg::EXT_ENABLE;
  wire go_dis    = last_addr && is_ext && ext == ee_pkg::EXT_DISABLE;
  wire need_data = op_reg == ee_pkg::OP_WRITE
                   || (is_ext && ext == ee_pkg::EXT_WRALL);

  // Programming accepted only when enabled and idle
  wire prog_req   = go_erase | go_erall | go_write | go_wrall;
  wire prog_start = prog_req && en_reg && !busy_reg;
  wire prog_done  = busy_reg && pcnt_reg == 32'h0;
  wire erase_op   = go_erase | go_erall;
  wire low_ok     = low_cnt_reg >= 6'(ee_pkg::MIN_SELECT_LOW_CYCLES);

  // Serial output next value
  wire so_next = go_read ? 1'b0
               : (state_reg == ee_pkg::D_READ && sk_rise) ? rsh_reg[15]
               : show_reg ? ~busy_reg
               : so_reg;
  wire so_en_next = cs_s && (go_read || state_reg == ee_pkg::D_READ
                             || show_reg);

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ee_pkg::D_IDLE;
      op_reg    <= 2'h0;
      addr_reg  <= '0;
      data_reg  <= 16'h0;
      rsh_reg   <= 16'h0;
      cnt_reg   <= 5'h0;
    end
    else if (!cs_s)
      state_reg <= ee_pkg::D_IDLE;
    else if (sk_rise)
    begin
      cnt_reg <= cnt_reg + 5'h1;
      case (state_reg)
        // Leading zeros skipped until the start bit
        ee_pkg::D_IDLE:
          if (di_s == ee_pkg::START_BIT)
          begin
            state_reg <= ee_pkg::D_OP;
            cnt_reg   <= 5'h0;
            addr_reg  <= '0;
          end
        ee_pkg::D_OP:
        begin
          op_reg <= {op_reg[0], di_s};
          if (cnt_reg == 5'h1)
          begin
            state_reg <= ee_pkg::D_ADDR;
            cnt_reg   <= 5'h0;
          end
        end
        ee_pkg::D_ADDR:
        begin
          addr_reg <= addr_full;
          if (cnt_reg == aw_last)
          begin
            cnt_reg   <= 5'h0;
            rsh_reg   <= rd_load;
            state_reg <= go_read ? ee_pkg::D_READ
                       : need_data ? ee_pkg::D_DATA : ee_pkg::D_IGNORE;
          end
        end
        ee_pkg::D_DATA:
        begin
          data_reg <= data_full;
          if (cnt_reg == dw_last)
            state_reg <= ee_pkg::D_IGNORE;
        end
        ee_pkg::D_READ:
          rsh_reg <= {rsh_reg[14:0], 1'b0};
        default:
          state_reg <= ee_pkg::D_IGNORE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Enable flag and self-timed programming cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en_reg        <= 1'b0;
      busy_reg      <= 1'b0;
      pcnt_reg      <= 32'h0;
      pend_all_reg  <= 1'b0;
      pend_idx_reg  <= '0;
      pend_data_reg <= 16'h0;
      pend_mask_reg <= 2'h0;
    end
    else
    begin
      if (go_en)
        en_reg <= 1'b1;
      else if (go_dis)
        en_reg <= 1'b0;
      if (prog_start)
      begin
        busy_reg      <= 1'b1;
        pcnt_reg      <= 32'(PROG_CYCLES - 1);
        pend_all_reg  <= go_erall | go_wrall;
        pend_idx_reg  <= idx;
        pend_data_reg <= erase_op ? ee_pkg::ERASED_WORD : wdata;
        pend_mask_reg <= (word_mode || go_erall || go_wrall) ? 2'h3
                       : (lane ? 2'h2 : 2'h1);
      end
      else if (prog_done)
        busy_reg <= 1'b0;
      else if (busy_reg)
        pcnt_reg <= pcnt_reg - 32'h1;
    end
  end

  // Array commit at end of cycle, one lane pair per word
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++)
    begin : g_word
      wire hit = prog_done && (pend_all_reg || pend_idx_reg == IDX_W'(gi));
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          mem[gi] <= ee_pkg::ERASED_WORD;
        else if (hit)
        begin
          if (pend_mask_reg[0])
            mem[gi][7:0] <= pend_data_reg[7:0];
          if (pend_mask_reg[1])
            mem[gi][15:8] <= pend_data_reg[15:8];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Ready/busy status and output drive
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_cnt_reg  <= 6'h0;
      armed_reg    <= 1'b0;
      show_reg     <= 1'b0;
      so_reg       <= 1'b0;
      so_en_reg    <= 1'b0;
      prog_busy    <= 1'b0;
      prog_enabled <= 1'b0;
    end
    else
    begin
      if (cs_s)
        low_cnt_reg <= 6'h0;
      else if (!low_ok)
        low_cnt_reg <= low_cnt_reg + 6'h1;
      // Status armed by a start, lost once the cycle ends or at the next select rise
      if (prog_start)
        armed_reg <= 1'b1;
      else if (prog_done || cs_rise)
        armed_reg <= 1'b0;
      if (cs_rise && armed_reg && busy_reg && low_ok)
        show_reg <= 1'b1;
      else if (!cs_s || (sk_rise && state_reg == ee_pkg::D_IDLE && di_s))
        show_reg <= 1'b0;
      so_reg       <= so_next;
      so_en_reg    <= so_en_next;
      prog_busy    <= busy_reg;
      prog_enabled <= en_reg;
    end
  end

  assign link.serial_out    = so_reg;
  assign link.serial_out_en = so_en_reg;

endmodule

/* verilog/ee_host.sv */
// Host end: frames commands onto the three-wire link
`timescale 1ns/1ns
module ee_host #(
  parameter int ADDR_W8 = ee_pkg::ADDR_W8_1K,
  parameter int HALF    = ee_pkg::SHIFT_HALF_CYCLES,
  parameter int MIN_SELECT_LOW_TIME     = ee_pkg::MIN_SELECT_LOW_CYCLES
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Link
  ee_link_if.host                   link,
  // Command request
  input  wire logic                 cmd_valid,
  input  ee_pkg::host_cmd_type      cmd,
  input  wire logic [ADDR_W8-1:0]   cmd_addr,
  input  wire logic [15:0]          cmd_data,
  input  wire logic                 word_mode,
  output logic                      cmd_ready,
  // Completion
  output logic                      done,
  output logic                      rd_valid,
  output logic [15:0]               rd_data
);

  ee_pkg::host_state_type state_reg;
  logic [31:0] frame_reg;
  logic [5:0]  left_reg;
  logic [4:0]  dw_reg;
  logic [15:0] div_reg;
  logic        phase_reg;
  logic        prog_reg;
  logic        read_reg;
  logic        cs_reg;
  logic        sk_reg;
  logic        di_reg;
  logic        org_reg;
  logic [1:0]  do_sync_reg;

  // ----------------------------------------------------------------------
  // Frame builder
  // ----------------------------------------------------------------------
  wire is_ext  = cmd == ee_pkg::program_enable_cmd
              || cmd == ee_pkg::program_disable_cmd
              || cmd == ee_pkg::erase_all_cmd
              || cmd == ee_pkg::write_all_cmd;
  wire [1:0] op = is_ext ? ee_pkg::OP_EXT
                : cmd == ee_pkg::cmd_read  ? ee_pkg::OP_READ
                : cmd == ee_pkg::cmd_write ? ee_pkg::OP_WRITE
                : ee_pkg::OP_ERASE;
  wire [1:0] ext = cmd == ee_pkg::program_enable_cmd  ? ee_pkg::EXT_ENABLE
                 : cmd == ee_pkg::erase_all_cmd       ? ee_pkg::EXT_ERALL
                 : cmd == ee_pkg::write_all_cmd       ? ee_pkg::EXT_WRALL
                 : ee_pkg::EXT_DISABLE;
  wire has_data = cmd == ee_pkg::cmd_read || cmd == ee_pkg::cmd_write
               || cmd == ee_pkg::write_all_cmd;
  wire [4:0] aw = word_mode ? 5'(ADDR_W8 - 1) : 5'(ADDR_W8);
  wire [4:0] dw = word_mode ? 5'(ee_pkg::DATA_W_WORD)
                            : 5'(ee_pkg::DATA_W_BYTE);
  wire [4:0] dlen = has_data ? dw : 5'h0;
  // Don't-care bits still take a slot, sent as zero
  wire [31:0] addr_f = is_ext ? (32'(ext) << (aw - 5'h2))
                              : 32'(cmd_addr) & ((32'h1 << aw) - 32'h1);
  wire [31:0] data_f = (cmd == ee_pkg::cmd_read) ? 32'h0
                     : word_mode ? 32'(cmd_data) : 32'(cmd_data[7:0]);
  wire [5:0]  nbits  = 6'h3 + 6'(aw) + 6'(dlen);
  wire [31:0] raw    = (32'({ee_pkg::START_BIT, op}) << (aw + dlen))
                     | (addr_f << dlen) | data_f;
  wire [31:0] frame  = raw << (6'd32 - nbits);
  wire        tick   = div_reg == 16'(HALF - 1);
  wire        do_s   = do_sync_reg[1];

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg   <= ee_pkg::H_TAIL;
      frame_reg   <= 32'h0;
      // Nonzero so the tail after reset gives no done pulse
      left_reg    <= 6'h3f;
      dw_reg      <= 5'h0;
      div_reg     <= 16'h0;
      phase_reg   <= 1'b0;
      prog_reg    <= 1'b0;
      read_reg    <= 1'b0;
      cs_reg      <= 1'b0;
      sk_reg      <= 1'b0;
      di_reg      <= 1'b0;
      org_reg     <= 1'b0;
      do_sync_reg <= 2'h0;
      cmd_ready   <= 1'b0;
      done        <= 1'b0;
      rd_valid    <= 1'b0;
      rd_data     <= 16'h0;
    end
    else
    begin
      do_sync_reg <= {do_sync_reg[0], link.serial_out_line};
      done        <= 1'b0;
      rd_valid    <= 1'b0;
      // Half-period count wraps only while shifting
      div_reg     <= (tick && state_reg == ee_pkg::H_SHIFT) ? 16'h0
                                                            : div_reg + 16'h1;
      case (state_reg)
        ee_pkg::H_IDLE:
        begin
          div_reg <= 16'h0;
          if (cmd_valid)
          begin
            state_reg <= ee_pkg::H_SHIFT;
            cmd_ready <= 1'b0;
            frame_reg <= {frame[30:0], 1'b0};
            di_reg    <= frame[31];
            left_reg  <= nbits;
            dw_reg    <= dw;
            org_reg   <= word_mode;
            prog_reg  <= op != ee_pkg::OP_READ
                         && !(is_ext && ext[1] == ext[0]);
            read_reg  <= cmd == ee_pkg::cmd_read;
            rd_data   <= 16'h0;
            cs_reg    <= 1'b1;
            phase_reg <= 1'b0;
          end
        end
        ee_pkg::H_SHIFT:
          if (tick)
          begin
            phase_reg <= ~phase_reg;
            sk_reg    <= ~phase_reg;
            if (phase_reg)
            begin
              if (read_reg && left_reg <= 6'(dw_reg))
                rd_data <= {rd_data[14:0], do_s};
              di_reg    <= frame_reg[31];
              frame_reg <= {frame_reg[30:0], 1'b0};
              left_reg  <= left_reg - 6'h1;
              if (left_reg == 6'h1)
              begin
                cs_reg    <= 1'b0;
                di_reg    <= 1'b0;
                state_reg <= prog_reg ? ee_pkg::H_GAP : ee_pkg::H_TAIL;
              end
            end
          end
        // Select held low long enough, then raised to poll
        ee_pkg::H_GAP:
          if (div_reg == 16'(MIN_SELECT_LOW_TIME))
          begin
            cs_reg    <= 1'b1;
            div_reg   <= 16'h0;
            state_reg <= ee_pkg::H_POLL;
          end
        ee_pkg::H_POLL:
          if (div_reg >= 16'(MIN_SELECT_LOW_TIME) && do_s)
          begin
            cs_reg    <= 1'b0;
            div_reg   <= 16'h0;
            state_reg <= ee_pkg::H_TAIL;
          end
          else if (div_reg >= 16'(MIN_SELECT_LOW_TIME))
            div_reg <= div_reg;
        default:
          if (div_reg == 16'(MIN_SELECT_LOW_TIME))
          begin
            state_reg <= ee_pkg::H_IDLE;
            cmd_ready <= 1'b1;
            done      <= cmd_ready == 1'b0 && left_reg == 6'h0;
            rd_valid  <= read_reg && left_reg == 6'h0;
            read_reg  <= 1'b0;
          end
      endcase
    end
  end

  assign link.chip_select      = cs_reg;
  assign link.shift_clock      = sk_reg;
  assign link.serial_in        = di_reg;
  assign link.word_size_select = org_reg;

endmodule

/* verilog/ee_link_if.sv */
// Three-wire serial link between host controller and EEPROM
`timescale 1ns/1ns
interface ee_link_if;
  logic chip_select;
  logic shift_clock;
  logic serial_in;
  logic word_size_select;
  logic serial_out;
  logic serial_out_en;
  logic serial_out_line;

  // Released output line floats high
  assign serial_out_line = serial_out_en ? serial_out : 1'b1;

  modport device (input  chip_select, shift_clock, serial_in,
                         word_size_select,
                  output serial_out, serial_out_en);
  modport host   (output chip_select, shift_clock, serial_in,
                         word_size_select,
                  input  serial_out_line);
endinterface

/* verilog/ee_pkg.sv */
// Shared constants and types for the three-wire serial EEPROM link
package ee_pkg;

  // ----------------------------------------------------------------------
  // Opcodes and extended address prefixes
  // ----------------------------------------------------------------------
  localparam logic       START_BIT   = 1'b1;
  localparam logic [1:0] OP_EXT      = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_ERASE    = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRALL   = 2'h1;
  localparam logic [1:0] EXT_ERALL   = 2'h2;
  localparam logic [1:0] EXT_ENABLE  = 2'h3;

  // ----------------------------------------------------------------------
  // Field sizes and reset values
  // ----------------------------------------------------------------------
  localparam int          ADDR_W8_1K  = 7;
  localparam int          DATA_W_BYTE = 8;
  localparam int          DATA_W_WORD = 16;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 8;
  localparam int MIN_SELECT_LOW_TIME_NS = 250;
  localparam int MIN_SELECT_LOW_CYCLES  =
    (MIN_SELECT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLE_TIME_US  = 10000;
  localparam int PROGRAM_CYCLE_CYCLES   =
    PROGRAM_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_TIME_NS     = 250;
  localparam int SHIFT_HALF_CYCLES      =
    (SHIFT_HALF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    cmd_read            = 3'h0,
    program_enable_cmd  = 3'h1,
    program_disable_cmd = 3'h2,
    cmd_erase           = 3'h3,
    cmd_write           = 3'h4,
    erase_all_cmd       = 3'h5,
    write_all_cmd       = 3'h6
  } host_cmd_type;

  typedef enum logic [2:0] {
    D_IDLE   = 3'h0,
    D_OP     = 3'h1,
    D_ADDR   = 3'h2,
    D_DATA   = 3'h3,
    D_READ   = 3'h4,
    D_IGNORE = 3'h5
  } dev_state_type;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SHIFT = 3'h1,
    H_GAP   = 3'h2,
    H_POLL  = 3'h3,
    H_TAIL  = 3'h4
  } host_state_type;

endpackage
